// >>> hw/l1c_core.sv
// level-one instruction and data caches with shared inclusive last-level cache
// Notes on behaviour
// RL1 - icache 64 sets, 4 ways, 64B lines
// RL2 - dcache 4-way 32KB, MSHR count
// RL3 - LLC 128x8, two outstanding
// RL4 - virtual index, physical tag
// RL5 - inclusive, pseudo-random victim
// RL6 - MESI directory in LLC
// RL7 - fetch index, page, thread, valid
// RL8 - kill abandons fetch in flight
// RL9 - invalidate drops active line
// RL10 - fetch returns block, address, thread, fault
// RL11 - fetch ready when acceptable
// RL12 - data valid, address, store data
// RL13 - data ready only when acceptable
// RL14 - ordered while memory busy
// RL15 - has-data marks load data
// RL16 - nack makes queue reissue
// RL17 - data answer two cycles on
// RL18 - four data exception flags
// RL19 - five-bit command, four-bit size
// RL20 - request tag names owner
// RL21 - response tag returns owner
// RL22 - taken when valid and ready
module l1c_core
    import l1c_pkg::*;
(
    input  wire logic            CLK_I,
    input  wire logic            SRST_I,
    input  wire logic            CE_I,
    input  wire logic            FETCH_REQ_VALID_I,
    input  wire l1c_fetch_req_t  FETCH_REQ_I,
    input  wire logic            FETCH_KILL_I,
    input  wire logic            FETCH_INVAL_I,
    output logic                 FETCH_READY_O,
    output logic                 FETCH_RESP_VALID_O,
    output l1c_fetch_resp_t      FETCH_RESP_O,
    input  wire logic            DMEM_REQ_VALID_I,
    input  wire l1c_dreq_t       DMEM_REQ_I,
    input  wire logic            RESERVATION_CLEAR_I,
    output logic                 DMEM_READY_O,
    output logic                 DMEM_ORDERED_O,
    output logic                 DMEM_RESP_VALID_O,
    output l1c_dresp_t           DMEM_RESP_O,
    output logic                 MEM_REQ_VALID_O,
    output l1c_mreq_t            MEM_REQ_O,
    input  wire logic            MEM_REQ_READY_I,
    input  wire logic            MEM_RESP_VALID_I,
    input  wire logic [LINE_W-1:0] MEM_RESP_DATA_I
);
    // only valid bits, states and sharer bits reset
    logic [IC_TAG_W-1:0] ic_tag  [IC_SETS][IC_WAYS];
    logic [LINE_W-1:0]   ic_data [IC_SETS][IC_WAYS];
    logic [IC_WAYS-1:0]  ic_val  [IC_SETS];
    logic [DC_TAG_W-1:0] dc_tag  [DC_SETS][DC_WAYS];
    logic [LINE_W-1:0]   dc_data [DC_SETS][DC_WAYS];
    logic [DC_WAYS-1:0]  dc_val  [DC_SETS];
    logic [DC_TAG_W-1:0] llc_tag [LLC_SETS][LLC_WAYS];
    logic [LINE_W-1:0]   llc_data[LLC_SETS][LLC_WAYS];
    l1c_mesi_t           llc_st  [LLC_SETS][LLC_WAYS];
    logic [1:0]          llc_shr [LLC_SETS][LLC_WAYS];

    logic [15:0]         lfsr;
    l1c_eng_t            eng_state;
    logic [ADDR_W-1:0]   eng_addr;
    logic                eng_dc;
    logic                eng_hit;
    logic [2:0]          eng_way;
    logic [LINE_W-1:0]   eng_line;
    logic [1:0]          out_cnt;

    logic                f1_valid;
    l1c_fetch_req_t      f1;
    logic [ADDR_W-1:0]   act_addr;
    logic                d1_valid;
    l1c_dreq_t           d1;
    logic                res_valid;
    logic [ADDR_W-7:0]   res_line;

    logic [ADDR_W-1:0]   f_addr;
    logic [IC_WAYS-1:0]  f_hitv;
    logic [1:0]          f_hway;
    logic                f_hit;
    logic                f_fault;
    logic                f_done;
    logic                ic_miss;
    logic [ADDR_W-1:0]   d_a;
    logic [DC_WAYS-1:0]  d_hitv;
    logic [1:0]          d_hway;
    logic [LLC_WAYS-1:0] s_hitv;
    logic [2:0]          s_hway;
    logic [LLC_WAYS-1:0] e_hitv;
    logic [2:0]          e_hway;
    logic                d_hit;
    logic [63:0]         d_old;
    logic [63:0]         d_al;
    logic [63:0]         d_ld;
    logic [63:0]         d_res;
    logic [63:0]         d_wsh;
    logic [63:0]         st_word;
    logic [7:0]          d_be;
    logic [5:0]          d_shift;
    logic                d_is_ld;
    logic                d_mis;
    logic                d_pf;
    logic                d_fault;
    logic                sc_ok;
    logic                st_we;
    logic                dc_miss;
    logic                eng_start;
    logic                binv;
    logic [ADDR_W-1:0]   binv_addr;
    logic                fill;
    l1c_mesi_t           fill_st;
    logic [6:0]          e_set;

    // virtual set, identity-translated tag [RL4]
    assign f_addr = {f1.vpn, f1.idx};
    assign d_a    = d1.addr;
    for (genvar w = 0; w < LLC_WAYS; w++) begin : g_hit
        if (w < IC_WAYS) begin : g_l1
            assign f_hitv[w] = ic_val[f_addr[11:6]][w] && ic_tag[f_addr[11:6]][w] == f_addr[39:12];
            assign d_hitv[w] = dc_val[d_a[12:6]][w] && dc_tag[d_a[12:6]][w] == d_a[39:13];
        end
        assign s_hitv[w] = llc_st[d_a[12:6]][w] != MESI_I && llc_tag[d_a[12:6]][w] == d_a[39:13];
        assign e_hitv[w] = llc_st[e_set][w] != MESI_I && llc_tag[e_set][w] == eng_addr[39:13];
    end

    always_comb begin
        f_hway = 2'h0;
        d_hway = 2'h0;
        s_hway = 3'h0;
        e_hway = 3'h0;
        for (int w = 0; w < LLC_WAYS; w++) begin
            if (w < IC_WAYS && f_hitv[w]) f_hway = 2'(w);
            if (w < DC_WAYS && d_hitv[w]) d_hway = 2'(w);
            if (s_hitv[w]) s_hway = 3'(w);
            if (e_hitv[w]) e_hway = 3'(w);
        end
    end

    // one fetch held until hit, fault or kill
    assign f_hit   = |f_hitv;
    assign f_fault = |f_addr[ADDR_W-1:PHYS_W];
    assign f_done  = f1_valid && (f_hit || f_fault);
    assign ic_miss = f1_valid && !f_hit && !f_fault && !FETCH_KILL_I;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            f1_valid      <= 1'b0;
            FETCH_READY_O <= 1'b0;
        end else if (CE_I) begin
            if (FETCH_KILL_I) begin
                f1_valid <= 1'b0; // [RL8]
            end else if (FETCH_REQ_VALID_I && FETCH_READY_O) begin // [RL22] [RL7]
                f1_valid <= 1'b1;
                f1       <= FETCH_REQ_I;
            end else if (f_done) begin
                f1_valid <= 1'b0;
            end
            FETCH_READY_O <= FETCH_KILL_I || f_done
                          || (!f1_valid && !(FETCH_REQ_VALID_I && FETCH_READY_O)); // [RL11]
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            FETCH_RESP_VALID_O <= 1'b0;
            FETCH_RESP_O       <= '0;
            act_addr           <= '0;
        end else if (CE_I) begin
            FETCH_RESP_VALID_O <= f_done && !FETCH_KILL_I; // [RL10]
            if (f1_valid) act_addr <= f_addr;
            if (f_done) begin
                FETCH_RESP_O.block <= ic_data[f_addr[11:6]][f_hway][{f_addr[5:4], 7'h00} +: BLOCK_W];
                FETCH_RESP_O.vaddr <= f_addr;
                FETCH_RESP_O.fetch_return_thread <= f1.fetch_thread_number;
                FETCH_RESP_O.fault <= f_fault; // [RL10]
            end
        end
    end

    // one lookup stage, registered answer
    always_comb begin
        d_hit   = |d_hitv;
        d_shift = {d_a[2:0], 3'h0};
        d_old   = dc_data[d_a[12:6]][d_hway][{d_a[5:3], 6'h00} +: 64];
        d_al    = d_old >> d_shift;
        d_is_ld = d1.cmd == CMD_LOAD || d1.cmd == CMD_LR;
        d_mis   = |(d_a[2:0] & 3'((4'h1 << d1.access_size_code[1:0]) - 4'h1)); // [RL19]
        d_pf    = |d_a[ADDR_W-1:PHYS_W];
        d_fault = d_mis || d_pf;
        sc_ok   = res_valid && res_line == d_a[ADDR_W-1:6];
        case (d1.access_size_code[1:0])
            2'h0:    d_ld = d1.access_size_code[2] ? {56'h0, d_al[7:0]} : {{56{d_al[7]}}, d_al[7:0]};
            2'h1:    d_ld = d1.access_size_code[2] ? {48'h0, d_al[15:0]}
                                                   : {{48{d_al[15]}}, d_al[15:0]};
            2'h2:    d_ld = d1.access_size_code[2] ? {32'h0, d_al[31:0]}
                                                   : {{32{d_al[31]}}, d_al[31:0]};
            default: d_ld = d_al;
        endcase
        case (d1.cmd)
            CMD_SWAP: d_res = d1.data;
            CMD_ADD:  d_res = d_al + d1.data;
            CMD_XOR:  d_res = d_al ^ d1.data;
            CMD_OR:   d_res = d_al | d1.data;
            CMD_AND:  d_res = d_al & d1.data;
            default:  d_res = d1.data;
        endcase
        d_wsh = d_res << d_shift;
        d_be  = 8'((16'h1 << (5'h1 << d1.access_size_code[1:0])) - 16'h1) << d_a[2:0];
        for (int b = 0; b < 8; b++) begin
            st_word[b*8 +: 8] = d_be[b] ? d_wsh[b*8 +: 8] : d_old[b*8 +: 8];
        end
        st_we   = d1_valid && d_hit && !d_fault && !d_is_ld && (d1.cmd != CMD_SC || sc_ok);
        dc_miss = d1_valid && !d_hit && !d_fault;
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            d1_valid <= 1'b0;
        end else if (CE_I) begin
            d1_valid <= DMEM_REQ_VALID_I && DMEM_READY_O; // [RL22] [RL12]
            if (DMEM_REQ_VALID_I && DMEM_READY_O) d1 <= DMEM_REQ_I; // [RL20]
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            res_valid <= 1'b0;
            res_line  <= '0;
        end else if (CE_I) begin
            if (RESERVATION_CLEAR_I || (d1_valid && d1.cmd == CMD_SC)) begin
                res_valid <= 1'b0;
            end else if (d1_valid && d1.cmd == CMD_LR && d_hit && !d_fault) begin
                res_valid <= 1'b1;
                res_line  <= d_a[ADDR_W-1:6];
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            DMEM_RESP_VALID_O <= 1'b0;
            DMEM_RESP_O       <= '0;
        end else if (CE_I) begin
            DMEM_RESP_VALID_O <= d1_valid; // [RL17]
            DMEM_RESP_O.tag   <= d1.tag; // [RL21]
            DMEM_RESP_O.nack  <= dc_miss; // retry hits after refill [RL16]
            DMEM_RESP_O.has_data <= d1_valid && d_hit && !d_fault && d1.cmd != CMD_STORE; // [RL15]
            DMEM_RESP_O.data  <= d1.cmd == CMD_SC ? {63'h0, !sc_ok} : d_ld;
            DMEM_RESP_O.load_misalign_fault  <= d_is_ld && d_mis; // [RL18]
            DMEM_RESP_O.load_page_fault      <= d_is_ld && d_pf;
            DMEM_RESP_O.store_misalign_fault <= !d_is_ld && d_mis;
            DMEM_RESP_O.store_page_fault     <= !d_is_ld && d_pf;
        end
    end

    // one refill engine; ready drops to avoid fill/store races
    assign eng_start = eng_state == ENG_IDLE && (dc_miss || ic_miss);
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            DMEM_READY_O   <= 1'b0;
            DMEM_ORDERED_O <= 1'b0;
        end else if (CE_I) begin
            DMEM_READY_O   <= eng_state == ENG_IDLE && !eng_start; // [RL13] [RL2]
            DMEM_ORDERED_O <= eng_state != ENG_IDLE || eng_start || d1_valid; // [RL14]
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) lfsr <= LFSR_SEED;
        else if (CE_I) lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    // victim evicts first-level copies [RL5]
    assign e_set = eng_addr[12:6];
    assign binv = eng_state == ENG_LOOKUP && !(|e_hitv) && llc_st[e_set][lfsr[2:0]] != MESI_I;
    assign binv_addr = {llc_tag[e_set][lfsr[2:0]], e_set, 6'h00};
    assign fill = eng_state == ENG_FILL;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            for (int s = 0; s < IC_SETS; s++) ic_val[s] <= '0;
        end else if (CE_I) begin
            if (fill && !eng_dc) begin // [RL1]
                ic_tag[eng_addr[11:6]][lfsr[1:0]]  <= eng_addr[39:12];
                ic_data[eng_addr[11:6]][lfsr[1:0]] <= eng_line;
                ic_val[eng_addr[11:6]][lfsr[1:0]]  <= 1'b1; // [RL5]
            end
            for (int w = 0; w < IC_WAYS; w++) begin
                if (FETCH_INVAL_I && ic_tag[act_addr[11:6]][w] == act_addr[39:12])
                    ic_val[act_addr[11:6]][w] <= 1'b0; // [RL9]
                if (binv && ic_tag[binv_addr[11:6]][w] == binv_addr[39:12])
                    ic_val[binv_addr[11:6]][w] <= 1'b0;
                if (st_we && llc_shr[d_a[12:6]][s_hway][SHR_IC]
                    && ic_tag[d_a[11:6]][w] == d_a[39:12])
                    ic_val[d_a[11:6]][w] <= 1'b0; // [RL6]
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            for (int s = 0; s < DC_SETS; s++) dc_val[s] <= '0;
        end else if (CE_I) begin
            if (st_we) dc_data[d_a[12:6]][d_hway][{d_a[5:3], 6'h00} +: 64] <= st_word;
            if (fill && eng_dc) begin // [RL2]
                dc_tag[e_set][lfsr[1:0]]  <= eng_addr[39:13];
                dc_data[e_set][lfsr[1:0]] <= eng_line;
                dc_val[e_set][lfsr[1:0]]  <= 1'b1;
            end
            for (int w = 0; w < DC_WAYS; w++) begin
                if (binv && dc_tag[binv_addr[12:6]][w] == binv_addr[39:13])
                    dc_val[binv_addr[12:6]][w] <= 1'b0; // [RL5]
            end
        end
    end

    // writeback and read may overlap
    always_ff @(posedge CLK_I) begin
        if (SRST_I) out_cnt <= OUT_RESET;
        else if (CE_I) out_cnt <= 2'(out_cnt + 2'(MEM_REQ_VALID_O && MEM_REQ_READY_I)
                                - 2'(MEM_RESP_VALID_I)); // [RL3]
    end

    always_comb begin
        fill_st = MESI_S;
        if (eng_dc)
            fill_st = eng_hit && llc_shr[e_set][eng_way][SHR_IC] ? MESI_S
                    : (eng_hit && llc_st[e_set][eng_way] == MESI_M ? MESI_M : MESI_E);
        else if (eng_hit && llc_st[e_set][eng_way] == MESI_M)
            fill_st = MESI_M;
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            eng_state       <= ENG_IDLE;
            MEM_REQ_VALID_O <= 1'b0;
            MEM_REQ_O       <= '0;
            for (int s = 0; s < LLC_SETS; s++) begin
                for (int w = 0; w < LLC_WAYS; w++) begin
                    llc_st[s][w]  <= MESI_I;
                    llc_shr[s][w] <= 2'h0;
                end
            end
        end else if (CE_I) begin
            if (MEM_REQ_VALID_O && MEM_REQ_READY_I) MEM_REQ_VALID_O <= 1'b0;
            case (eng_state)
                ENG_IDLE: begin
                    if (dc_miss || ic_miss) begin
                        eng_addr  <= dc_miss ? d_a : f_addr;
                        eng_dc    <= dc_miss;
                        eng_state <= ENG_LOOKUP;
                    end
                end
                ENG_LOOKUP: begin
                    eng_hit <= |e_hitv;
                    if (|e_hitv) begin
                        eng_way   <= e_hway;
                        eng_line  <= llc_data[e_set][e_hway];
                        eng_state <= ENG_FILL;
                    end else begin
                        eng_way   <= lfsr[2:0]; // [RL5]
                        eng_state <= binv ? ENG_EVICT : ENG_READ;
                    end
                end
                ENG_EVICT: begin
                    // dirty bit read after lookup-cycle store
                    if (llc_st[e_set][eng_way] != MESI_M) begin
                        eng_state <= ENG_READ;
                    end else if (!MEM_REQ_VALID_O && out_cnt < 2'(LLC_MAX_OUT)) begin // [RL3]
                        MEM_REQ_VALID_O <= 1'b1;
                        MEM_REQ_O <= {1'b1, llc_tag[e_set][eng_way], e_set, 6'h00,
                                      llc_data[e_set][eng_way]};
                        eng_state <= ENG_READ;
                    end
                end
                ENG_READ: begin
                    if (!MEM_REQ_VALID_O && out_cnt < 2'(LLC_MAX_OUT)) begin // [RL3]
                        MEM_REQ_VALID_O <= 1'b1;
                        MEM_REQ_O <= {1'b0, eng_addr[39:6], 6'h00, {LINE_W{1'b0}}};
                        eng_state <= ENG_WAIT;
                    end
                end
                ENG_WAIT: begin
                    // in-order answers: read is last
                    if (MEM_RESP_VALID_I && out_cnt == 2'h1 && !MEM_REQ_VALID_O) begin
                        eng_line  <= MEM_RESP_DATA_I;
                        eng_state <= ENG_FILL;
                    end
                end
                ENG_FILL: begin
                    llc_tag[e_set][eng_way]  <= eng_addr[39:13]; // [RL3]
                    llc_data[e_set][eng_way] <= eng_line;
                    llc_st[e_set][eng_way]   <= fill_st; // [RL6]
                    llc_shr[e_set][eng_way]  <= (eng_hit ? llc_shr[e_set][eng_way] : 2'h0)
                        | (eng_dc ? 2'h2 : 2'h1);
                    eng_state <= ENG_IDLE;
                end
                default: eng_state <= ENG_IDLE;
            endcase
            if (st_we) begin
                // write-through keeps inclusion
                llc_data[d_a[12:6]][s_hway][{d_a[5:3], 6'h00} +: 64] <= st_word;
                llc_st[d_a[12:6]][s_hway]          <= MESI_M; // [RL6]
                llc_shr[d_a[12:6]][s_hway][SHR_IC] <= 1'b0;
            end
        end
    end
endmodule

// >>> inc/l1c_pkg.sv
// shared constants, types and payload structs of the level-one cache core
package l1c_pkg;
    localparam int ADDR_W      = 40;
    localparam int PHYS_W      = 32;
    localparam int LINE_W      = 512;
    localparam int BLOCK_W     = 128;
    localparam int IC_SETS     = 64;
    localparam int IC_WAYS     = 4;
    localparam int DC_SETS     = 128;
    localparam int DC_WAYS     = 4;
    localparam int LLC_SETS    = 128;
    localparam int LLC_WAYS    = 8;
    localparam int LLC_MAX_OUT = 2;
    localparam int DC_MSHRS    = 1;
    localparam int OFF_W       = 6;
    localparam int IC_IDX_W    = 6;
    localparam int DC_IDX_W    = 7;
    localparam int IC_TAG_W    = ADDR_W - OFF_W - IC_IDX_W;
    localparam int DC_TAG_W    = ADDR_W - OFF_W - DC_IDX_W;
    localparam int SHR_IC      = 0;
    localparam int SHR_DC      = 1;

    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [1:0]  OUT_RESET = 2'h0;

    localparam logic [4:0] CMD_LOAD  = 5'h00;
    localparam logic [4:0] CMD_STORE = 5'h01;
    localparam logic [4:0] CMD_SWAP  = 5'h04;
    localparam logic [4:0] CMD_LR    = 5'h06;
    localparam logic [4:0] CMD_SC    = 5'h07;
    localparam logic [4:0] CMD_ADD   = 5'h08;
    localparam logic [4:0] CMD_XOR   = 5'h09;
    localparam logic [4:0] CMD_OR    = 5'h0a;
    localparam logic [4:0] CMD_AND   = 5'h0b;

    typedef enum logic [1:0] {MESI_I, MESI_S, MESI_E, MESI_M} l1c_mesi_t;
    typedef enum logic [2:0] {
        ENG_IDLE, ENG_LOOKUP, ENG_EVICT, ENG_READ, ENG_WAIT, ENG_FILL
    } l1c_eng_t;

    typedef struct packed {
        logic [11:0] idx;
        logic [27:0] vpn;
        logic [1:0]  fetch_thread_number;
    } l1c_fetch_req_t;

    typedef struct packed {
        logic [BLOCK_W-1:0] block;
        logic [ADDR_W-1:0]  vaddr;
        logic [1:0]         fetch_return_thread;
        logic               fault;
    } l1c_fetch_resp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [63:0]       data;
        logic [4:0]        cmd;
        logic [3:0]        access_size_code;
        logic [7:0]        tag;
    } l1c_dreq_t;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  tag;
        logic        has_data;
        logic        nack;
        logic        store_misalign_fault;
        logic        load_misalign_fault;
        logic        store_page_fault;
        logic        load_page_fault;
    } l1c_dresp_t;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [LINE_W-1:0] data;
    } l1c_mreq_t;
endpackage

// >>> verification/l1c_core_asserts.sv
// port-level checks on the cache core
module l1c_core_asserts
    import l1c_pkg::*;
(
    input wire logic            CLK_I,
    input wire logic            SRST_I,
    input wire logic            CE_I,
    input wire logic            FETCH_REQ_VALID_I,
    input wire l1c_fetch_req_t  FETCH_REQ_I,
    input wire logic            FETCH_KILL_I,
    input wire logic            FETCH_READY_O,
    input wire logic            FETCH_RESP_VALID_O,
    input wire l1c_fetch_resp_t FETCH_RESP_O,
    input wire logic            DMEM_REQ_VALID_I,
    input wire l1c_dreq_t       DMEM_REQ_I,
    input wire logic            DMEM_READY_O,
    input wire logic            DMEM_ORDERED_O,
    input wire logic            DMEM_RESP_VALID_O,
    input wire l1c_dresp_t      DMEM_RESP_O,
    input wire logic            MEM_REQ_VALID_O,
    input wire l1c_mreq_t       MEM_REQ_O,
    input wire logic            MEM_REQ_READY_I
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    wire f_take = CE_I && FETCH_REQ_VALID_I && FETCH_READY_O && !FETCH_KILL_I;
    wire d_take = CE_I && DMEM_REQ_VALID_I && DMEM_READY_O;
    sequence d_req; d_take ##1 CE_I; endsequence
    sequence f_bad; f_take && FETCH_REQ_I.vpn[27:20] != 8'h00 ##1 CE_I; endsequence
    chk_dresp_late: assert property (
        d_req |=> DMEM_RESP_VALID_O) else $error("data answer missing");
    chk_dresp_early: assert property (
        DMEM_RESP_VALID_O |-> $past(d_take, 2)) else $error("data answer early");
    chk_dtag_echo: assert property (
        d_req |=> DMEM_RESP_O.tag == $past(DMEM_REQ_I.tag, 2)) else $error("tag lost");
    chk_data_flag: assert property (
        DMEM_RESP_VALID_O && DMEM_RESP_O.has_data |-> !DMEM_RESP_O.nack) else $error("nack data");
    chk_fault_quiet: assert property (
        DMEM_RESP_VALID_O && |DMEM_RESP_O[3:0] |-> !DMEM_RESP_O[5] && !DMEM_RESP_O[4])
        else $error("fault with data");
    chk_miss_ordered: assert property (
        DMEM_RESP_VALID_O && DMEM_RESP_O.nack |-> DMEM_ORDERED_O && !DMEM_READY_O)
        else $error("miss not busy");
    chk_fetch_busy: assert property (
        f_take |=> !FETCH_READY_O) else $error("second fetch open");
    chk_fetch_ready: assert property (
        FETCH_RESP_VALID_O |-> FETCH_READY_O) else $error("not ready at answer");
    chk_kill_silent: assert property (
        CE_I && FETCH_KILL_I |=> !FETCH_RESP_VALID_O) else $error("killed fetch answered");
    chk_fetch_fault: assert property (
        f_bad |=> FETCH_RESP_VALID_O && FETCH_RESP_O.fault) else $error("fault missing");
    chk_mem_hold: assert property (
        MEM_REQ_VALID_O && !MEM_REQ_READY_I |=> MEM_REQ_VALID_O && $stable(MEM_REQ_O))
        else $error("memory request dropped");
endmodule
bind l1c_core l1c_core_asserts chk (.*);

// >>> verification/l1c_mem_model.sv
// in-order line memory model
module l1c_mem_model
    import l1c_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic         req_valid_i,
    input  wire l1c_mreq_t    req_i,
    output logic              req_ready_o = 1'b0,
    output logic              resp_valid_o = 1'b0,
    output logic [LINE_W-1:0] resp_data_o = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [LINE_W-1:0] mem [logic [ADDR_W-1:0]];
    l1c_mreq_t         pend [$];
    l1c_mreq_t         head;
    logic [3:0]        cnt = 4'h0;
    always @(posedge clk_i) begin
        cnt <= cnt + 4'h1;
        resp_valid_o <= 1'b0;
        resp_data_o <= ~resp_data_o; // idle bus inverts its value every cycle
        req_ready_o <= cnt[1:0] != 2'h3; // stalls one cycle in four
        if (srst_i) begin
            pend.delete();
        end else begin
            if (req_valid_i && req_ready_o) pend.push_back(req_i);
            if (pend.size() > 0 && cnt[2]) begin
                head = pend.pop_front();
                resp_valid_o <= 1'b1;
                if (head.write) mem[head.addr] = head.data;
                else resp_data_o <= mem.exists(head.addr) ? mem[head.addr]
                                                          : {16{head.addr[31:0]}};
            end
        end
    end
endmodule

// >>> verification/tb_l1c_core.sv
// self-checking bench of the cache core
module tb_l1c_core import l1c_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, fv = 1'b0, kill = 1'b0, inv = 1'b0;
    logic dv = 1'b0, rclr = 1'b0, f_rdy, f_rv, d_rdy, d_ord, d_rv, m_v, m_rdy, m_rv;
    l1c_fetch_req_t    fr = '0;
    l1c_fetch_resp_t   fo;
    l1c_dreq_t         dr = '0;
    l1c_dresp_t        dq;
    l1c_mreq_t         mq;
    logic [LINE_W-1:0] md;
    int errors = 0, comparisons = 0, cyc = 0;
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
    l1c_core dut (.CLK_I(clk), .SRST_I(srst), .CE_I(ce), .FETCH_REQ_VALID_I(fv),
        .FETCH_REQ_I(fr), .FETCH_KILL_I(kill), .FETCH_INVAL_I(inv), .FETCH_READY_O(f_rdy),
        .FETCH_RESP_VALID_O(f_rv), .FETCH_RESP_O(fo), .DMEM_REQ_VALID_I(dv),
        .DMEM_REQ_I(dr), .RESERVATION_CLEAR_I(rclr), .DMEM_READY_O(d_rdy),
        .DMEM_ORDERED_O(d_ord), .DMEM_RESP_VALID_O(d_rv), .DMEM_RESP_O(dq),
        .MEM_REQ_VALID_O(m_v), .MEM_REQ_O(mq), .MEM_REQ_READY_I(m_rdy),
        .MEM_RESP_VALID_I(m_rv), .MEM_RESP_DATA_I(md));
    l1c_mem_model mem (.clk_i(clk), .srst_i(srst), .req_valid_i(m_v), .req_i(mq),
        .req_ready_o(m_rdy), .resp_valid_o(m_rv), .resp_data_o(md));
    initial forever #2 clk = ~clk;
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin errors++; wrap_up(); end
    end
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic fetch(logic [39:0] a, logic [1:0] t, output int lat);
        int w = 0;
        while (f_rdy !== 1'b1 && w < 300) begin step(); w++; end
        fr = '{a[11:0], a[39:12], t};
        fv = 1'b1;
        step();
        fv = 1'b0;
        lat = 1;
        while (f_rv !== 1'b1 && lat < 300) begin step(); lat++; end
    endtask
    task automatic dreq(logic [4:0] c, logic [3:0] s, logic [39:0] a, logic [63:0] d,
                        logic [7:0] t);
        int w = 0;
        do begin
            while (d_rdy !== 1'b1 && w < 500) begin step(); w++; end
            dr = '{a, d, c, s, t};
            dv = 1'b1;
            step();
            dv = 1'b0;
            step();
            w++;
        end while (dq.nack === 1'b1 && w < 500);
        `CHK("data tag", t, dq.tag)
    endtask
    task automatic t_fetch();
        int lat;
        fetch(40'h1240, 2'h2, lat);
        `CHK("fetch block", {4{32'h1240}}, fo.block)
        `CHK("fetch addr", 40'h1240, fo.vaddr)
        `CHK("fetch thread", 2'h2, fo.fetch_return_thread)
        fetch(40'h1270, 2'h1, lat);
        `CHK("hit latency", 2, lat)
        inv = 1'b1;
        step();
        inv = 1'b0;
        fetch(40'h1240, 2'h0, lat);
        `CHK("refetch", 1'b1, lat > 2)
        fetch(40'h0100000040, 2'h3, lat);
        `CHK("fetch fault", 1'b1, fo.fault)
    endtask
    task automatic t_kill();
        int w = 0;
        fr = '{12'h400, 28'h0000002, 2'h3};
        fv = 1'b1;
        step();
        fv = 1'b0;
        kill = 1'b1;
        step();
        kill = 1'b0;
        repeat (60) begin step(); w += (f_rv === 1'b1); end
        `CHK("killed answers", 0, w)
    endtask
    task automatic t_data();
        dreq(CMD_LOAD, 4'h3, 40'h8010, '0, 8'h11);
        `CHK("load data", {2{32'h8000}}, dq.data)
        `CHK("load has data", 1'b1, dq.has_data)
        dreq(CMD_STORE, 4'h3, 40'h8010, 64'h0123456789abcdef, 8'h22);
        `CHK("store has data", 1'b0, dq.has_data)
        dreq(CMD_LOAD, 4'h2, 40'h8014, '0, 8'h33);
        `CHK("word load", 64'h1234567, dq.data)
        dreq(CMD_LOAD, 4'h0, 40'h8010, '0, 8'h44);
        `CHK("byte load", 64'hffffffffffffffef, dq.data)
        dreq(CMD_SWAP, 4'h3, 40'h8010, 64'hf0, 8'h55);
        `CHK("swap old", 64'h0123456789abcdef, dq.data)
        dreq(CMD_AND, 4'h3, 40'h8010, 64'h30, 8'h66);
        `CHK("and old", 64'hf0, dq.data)
        dreq(CMD_LOAD, 4'h3, 40'h8010, '0, 8'h77);
        `CHK("and result", 64'h30, dq.data)
    endtask
    task automatic t_faults();
        logic [4:0]  c [4] = '{CMD_LOAD, CMD_STORE, CMD_LOAD, CMD_STORE};
        logic [39:0] a [4] = '{40'h8011, 40'h8013, 40'h0200008010, 40'h0300008010};
        logic [3:0]  e [4] = '{4'b0100, 4'b1000, 4'b0001, 4'b0010};
        for (int i = 0; i < 4; i++) begin
            dreq(c[i], 4'h3, a[i], '0, 8'(64 + i));
            `CHK("fault flags", {2'b00, e[i]}, {dq.has_data, dq.nack, dq[3:0]})
        end
    endtask
    initial begin
        step(16);
        `CHK("ready in reset", 2'b00, {f_rdy, d_rdy})
        srst = 1'b0;
        step();
        `CHK("ready after reset", 2'b11, {f_rdy, d_rdy})
        t_fetch();
        t_kill();
        t_data();
        t_faults();
        wrap_up();
    end
endmodule
